// ==== ssas_pkg.sv ====
package ssas_pkg;

   // ***************************************************
   // Operation codes
   // ***************************************************
   typedef enum logic [3:0] {
      SSAS_OP_ADD_HALF     = 4'h0,
      SSAS_OP_ADD_BYTE     = 4'h1,
      SSAS_OP_HADD_HALF    = 4'h2,
      SSAS_OP_HADD_BYTE    = 4'h3,
      SSAS_OP_HADD_SUB_X   = 4'h4,
      SSAS_OP_HSUB_ADD_X   = 4'h5,
      SSAS_OP_HSUB_HALF    = 4'h6,
      SSAS_OP_HSUB_BYTE    = 4'h7,
      SSAS_OP_SUB_HALF     = 4'h8,
      SSAS_OP_SUB_BYTE     = 4'h9,
      SSAS_OP_ADD_SUB_X    = 4'hA,
      SSAS_OP_SUB_ADD_X    = 4'hB
   } ssas_op_t;

   localparam int              SSAS_WORD_W   = 32;
   localparam int              SSAS_REG_AW   = 4;
   localparam int              SSAS_NUM_REGS = 16;
   localparam logic [31:0]     SSAS_RST_WORD = 32'h0000_0000;
   localparam logic [3:0]      SSAS_RST_IDX  = 4'h0;

endpackage

// ==== ssas_lane_unit.sv ====
`timescale 1ns/1ps
module ssas_lane_unit (
   input  wire logic [3:0]  i_op,
   input  wire logic [31:0] i_first,
   input  wire logic [31:0] i_second,
   output logic      [31:0] o_result,
   output logic             o_valid_op
);
   // ***************************************************
   // Lane arithmetic
   // ***************************************************
   // Lanes are sign-extended by one bit so halving keeps full precision
   function automatic logic [15:0] half_op(input logic [15:0] a, input logic [15:0] b,
                                           input logic sub, input logic halve);
      logic [16:0] s;
      s = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
      half_op = halve ? s[16:1] : s[15:0];
   endfunction

   function automatic logic [7:0] byte_op(input logic [7:0] a, input logic [7:0] b,
                                          input logic sub, input logic halve);
      logic [8:0] s;
      s = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
      byte_op = halve ? s[8:1] : s[7:0];
   endfunction

   always_comb begin
      o_result   = 32'h0000_0000;
      o_valid_op = 1'b1;
      unique case (ssas_pkg::ssas_op_t'(i_op))
         // RULE_01: halfword add
         ssas_pkg::SSAS_OP_ADD_HALF: begin
            o_result = {half_op(i_first[31:16], i_second[31:16], 1'b0, 1'b0),
                        half_op(i_first[15:0], i_second[15:0], 1'b0, 1'b0)};
         end
         // RULE_03: halving halfword add
         ssas_pkg::SSAS_OP_HADD_HALF: begin
            o_result = {half_op(i_first[31:16], i_second[31:16], 1'b0, 1'b1),
                        half_op(i_first[15:0], i_second[15:0], 1'b0, 1'b1)};
         end
         // RULE_09: halving halfword subtract
         ssas_pkg::SSAS_OP_HSUB_HALF: begin
            o_result = {half_op(i_first[31:16], i_second[31:16], 1'b1, 1'b1),
                        half_op(i_first[15:0], i_second[15:0], 1'b1, 1'b1)};
         end
         // RULE_11: halfword subtract
         ssas_pkg::SSAS_OP_SUB_HALF: begin
            o_result = {half_op(i_first[31:16], i_second[31:16], 1'b1, 1'b0),
                        half_op(i_first[15:0], i_second[15:0], 1'b1, 1'b0)};
         end
         // RULE_05: halved top sum
         // RULE_06: halved bottom difference
         ssas_pkg::SSAS_OP_HADD_SUB_X: begin
            o_result = {half_op(i_first[31:16], i_second[15:0], 1'b0, 1'b1),
                        half_op(i_first[15:0], i_second[31:16], 1'b1, 1'b1)};
         end
         // RULE_07: halved bottom sum
         // RULE_08: halved top difference
         ssas_pkg::SSAS_OP_HSUB_ADD_X: begin
            o_result = {half_op(i_first[31:16], i_second[15:0], 1'b1, 1'b1),
                        half_op(i_first[15:0], i_second[31:16], 1'b0, 1'b1)};
         end
         // RULE_13: top sum exchanged
         // RULE_18: bottom difference exchanged
         ssas_pkg::SSAS_OP_ADD_SUB_X: begin
            o_result = {half_op(i_first[31:16], i_second[15:0], 1'b0, 1'b0),
                        half_op(i_first[15:0], i_second[31:16], 1'b1, 1'b0)};
         end
         // RULE_18: sub-add exchanged forms
         ssas_pkg::SSAS_OP_SUB_ADD_X: begin
            o_result = {half_op(i_first[31:16], i_second[15:0], 1'b1, 1'b0),
                        half_op(i_first[15:0], i_second[31:16], 1'b0, 1'b0)};
         end
         // RULE_02: byte add
         // RULE_19: lanes wrap independently
         ssas_pkg::SSAS_OP_ADD_BYTE: begin
            for (int k = 0; k < 4; k++) begin
               o_result[k*8 +: 8] = byte_op(i_first[k*8 +: 8], i_second[k*8 +: 8], 1'b0, 1'b0);
            end
         end
         // RULE_03: halving byte add
         // RULE_04: full precision halving
         ssas_pkg::SSAS_OP_HADD_BYTE: begin
            for (int k = 0; k < 4; k++) begin
               o_result[k*8 +: 8] = byte_op(i_first[k*8 +: 8], i_second[k*8 +: 8], 1'b0, 1'b1);
            end
         end
         // RULE_10: halving byte subtract
         ssas_pkg::SSAS_OP_HSUB_BYTE: begin
            for (int k = 0; k < 4; k++) begin
               o_result[k*8 +: 8] = byte_op(i_first[k*8 +: 8], i_second[k*8 +: 8], 1'b1, 1'b1);
            end
         end
         // RULE_12: byte subtract
         ssas_pkg::SSAS_OP_SUB_BYTE: begin
            for (int k = 0; k < 4; k++) begin
               o_result[k*8 +: 8] = byte_op(i_first[k*8 +: 8], i_second[k*8 +: 8], 1'b1, 1'b0);
            end
         end
         default: begin
            o_valid_op = 1'b0;
         end
      endcase
   end
endmodule

// ==== ssas_unit.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE_01: Halfword lanes added pairwise
// RULE_02: Four byte lanes added pairwise
// RULE_03: Halving add for halfword and byte
// RULE_04: Halving shifts full-precision result right one
// RULE_05: Halving exchange top is halved sum
// RULE_06: Halving exchange bottom is halved difference
// RULE_07: Sub-add exchange bottom is halved sum
// RULE_08: Sub-add exchange top is halved difference
// RULE_09: Halving halfword subtract per lane
// RULE_10: Halving byte subtract per lane
// RULE_11: Halfword subtract per lane
// RULE_12: Byte subtract per lane
// RULE_13: Exchange top is plain signed sum
// RULE_14: Condition flags never modified
// RULE_15: Stack pointer, program counter never selected; unit does not check, any index 0-15 can be the write register
// RULE_16: False predicate leaves destination unchanged
// RULE_17: Omitted destination means first operand register
// RULE_18: Exchange forms place sum and difference
// RULE_19: Lanes wrap, no carry between lanes
module ssas_unit #(
   parameter int NUM_REGS = ssas_pkg::SSAS_NUM_REGS
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_issue,
   input  wire logic [3:0]  i_op,
   input  wire logic        i_cond_pass,
   input  wire logic        i_dest_given,
   input  wire logic [3:0]  i_dest_reg,
   input  wire logic [3:0]  i_first_operand_reg,
   input  wire logic [3:0]  i_second_operand_reg,
   input  wire logic [31:0] i_first,
   input  wire logic [31:0] i_second,
   input  wire logic [3:0]  i_flags,
   output logic             o_write_en,
   output logic      [3:0]  o_write_reg,
   output logic      [31:0] o_write_data,
   output logic      [3:0]  o_flags,
   output logic             o_bad_op
);
   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic        write_en;
      logic [3:0]  write_reg;
      logic [31:0] write_data;
      logic [3:0]  flags;
      logic        bad_op;
   } ssas_state_t;

   ssas_state_t state;
   ssas_state_t next_state;
   logic [31:0] lane_result;
   logic        lane_valid;

   ssas_lane_unit u_lanes (
      .i_op       (i_op),
      .i_first    (i_first),
      .i_second   (i_second),
      .o_result   (lane_result),
      .o_valid_op (lane_valid)
   );

   // ***************************************************
   // Next state
   // ***************************************************
   // Result is registered one cycle; the decoder keeps register choices legal
   always_comb begin
      next_state          = state;
      next_state.write_en = 1'b0;
      next_state.bad_op   = 1'b0;
      // RULE_14: flags pass through
      next_state.flags    = i_flags;
      if (i_issue) begin
         next_state.bad_op = ~lane_valid;
         // RULE_16: predicate gates write
         next_state.write_en = i_cond_pass & lane_valid;
         // RULE_17: default destination
         next_state.write_reg = i_dest_given ? i_dest_reg : i_first_operand_reg;
         next_state.write_data = lane_result;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= '{1'b0, ssas_pkg::SSAS_RST_IDX, ssas_pkg::SSAS_RST_WORD, 4'h0, 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign o_write_en   = state.write_en;
   assign o_write_reg  = state.write_reg;
   assign o_write_data = state.write_data;
   assign o_flags      = state.flags;
   assign o_bad_op     = state.bad_op;
endmodule

// ==== ssas_monitor.sv ====
`timescale 1ns/1ps
module ssas_monitor (
   input wire logic        i_sys_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_issue,
   input wire logic [3:0]  i_op,
   input wire logic        i_cond_pass,
   input wire logic        i_dest_given,
   input wire logic [3:0]  i_dest_reg,
   input wire logic [3:0]  i_first_operand_reg,
   input wire logic [31:0] i_first,
   input wire logic [31:0] i_second,
   input wire logic [3:0]  i_flags,
   input wire logic        o_write_en,
   input wire logic [3:0]  o_write_reg,
   input wire logic [31:0] o_write_data,
   input wire logic [3:0]  o_flags,
   input wire logic        o_bad_op
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic        go     = i_issue && i_op <= 4'hB && i_cond_pass;
   wire logic [15:0] add_lo = i_first[15:0] + i_second[15:0];
   wire logic [7:0]  sub_b3 = i_first[31:24] - i_second[31:24];
   a_write_taken: assert property (go |=> o_write_en)
      else $error("write missing");
   a_false_held: assert property (i_issue && !i_cond_pass |=> !o_write_en)
      else $error("write on false predicate");
   a_bad_refused: assert property (i_issue && i_cond_pass && i_op > 4'hB |=> o_bad_op && !o_write_en)
      else $error("illegal op not refused");
   a_flags_kept: assert property (!$past(i_sys_rst) |-> o_flags == $past(i_flags))
      else $error("flags altered");
   a_dest_omitted: assert property (go && !i_dest_given |=> o_write_reg == $past(i_first_operand_reg))
      else $error("omitted destination wrong");
   a_dest_named: assert property (go && i_dest_given |=> o_write_reg == $past(i_dest_reg))
      else $error("named destination wrong");
   a_half_add: assert property (go && i_op == 4'h0 |=> o_write_data[15:0] == $past(add_lo))
      else $error("halfword sum wrong");
   a_byte_sub: assert property (go && i_op == 4'h9 |=> o_write_data[31:24] == $past(sub_b3))
      else $error("byte difference wrong");
   a_no_spurious: assert property (o_write_en || o_bad_op |-> $past(i_issue))
      else $error("pulse without issue");
endmodule
bind ssas_unit ssas_monitor u_mon (.*);

// ==== ssas_reg_model.sv ====
`timescale 1ns/1ps
module ssas_reg_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_write_en,
   input  wire logic [3:0]  i_write_reg,
   input  wire logic [31:0] i_write_data,
   input  wire logic [3:0]  i_peek_reg,
   output logic      [31:0] o_peek_data
);
   // Register file seen by the unit; only written on the result pulse
   logic [31:0] regs [16];
   always_ff @(posedge i_sys_clk) begin
      if (i_write_en) begin
         regs[i_write_reg] <= i_write_data;
      end
   end
   assign o_peek_data = regs[i_peek_reg];
endmodule

// ==== simd_signed_add_sub_bench.sv ====
`timescale 1ns/1ps
module simd_signed_add_sub_bench;
   logic        i_sys_clk = 0, i_sys_rst = 1, i_issue = 0, i_cond_pass = 0, i_dest_given = 0;
   logic [3:0]  i_op = '0, i_dest_reg = '0, i_first_operand_reg = '0, i_flags = '0;
   logic [31:0] i_first = '0, i_second = '0;
   logic        o_write_en, o_bad_op, exp_en = 0, exp_bad = 0;
   logic [3:0]  o_write_reg, o_flags, exp_reg = '0, exp_flags = '0;
   logic [31:0] o_write_data, exp_data = '0, peek;
   int          failures = 0, n_compared = 0;
   always #50 i_sys_clk = ~i_sys_clk;
   ssas_unit u_dut (.*, .i_second_operand_reg(4'h2));
   ssas_reg_model u_regs (.i_sys_clk(i_sys_clk), .i_write_en(o_write_en),
      .i_write_reg(o_write_reg), .i_write_data(o_write_data), .i_peek_reg(4'h3), .o_peek_data(peek));
   // ****************************
   // Checking helpers
   // ****************************
   task automatic check(logic [31:0] seen, logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task wrap_up;
      if (failures == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Lane arithmetic in plain integers, so wrap and halving are explicit
   function automatic logic [31:0] calc(logic [3:0] op, logic [31:0] a, logic [31:0] b);
      int x, y, s, w;
      logic sub, exch;
      logic [31:0] r;
      w = op inside {1, 3, 7, 9} ? 8 : 16;
      exch = op inside {4, 5, 10, 11};
      for (int k = 0; k < 32 / w; k++) begin
         x = w == 8 ? $signed(a[8*k+:8]) : $signed(a[16*k+:16]);
         y = exch ? $signed(b[16*(1-k)+:16]) : w == 8 ? $signed(b[8*k+:8]) : $signed(b[16*k+:16]);
         sub = op inside {6, 7, 8, 9} || (op inside {4, 10} && k == 0) || (op inside {5, 11} && k == 1);
         s = sub ? x - y : x + y;
         if (op inside {[2:7]}) s = s >>> 1;
         if (w == 8) r[8*k+:8] = s[7:0];
         else r[16*k+:16] = s[15:0];
      end
      return r;
   endfunction
   // Issue one operation and judge the one taken a cycle earlier
   task automatic step(logic go, logic [3:0] op, logic [31:0] a, logic [31:0] b, logic pass,
                       logic given);
      @(posedge i_sys_clk);
      i_issue <= go;
      i_op <= op;
      i_first <= a;
      i_second <= b;
      i_cond_pass <= pass;
      i_dest_given <= given;
      i_dest_reg <= 4'h3;
      i_first_operand_reg <= 4'h5;
      i_flags <= a[3:0];
      @(negedge i_sys_clk);
      check(o_write_en, exp_en);
      check(o_bad_op, exp_bad);
      check(o_flags, exp_flags);
      if (exp_en) check(o_write_data, exp_data);
      if (exp_en) check(o_write_reg, exp_reg);
      exp_en = go && pass && op <= 4'hB;
      // The unit flags an illegal code whatever the predicate says
      exp_bad = go && op > 4'hB;
      exp_reg = given ? 4'h3 : 4'h5;
      exp_data = calc(op, a, b);
      exp_flags = a[3:0];
   endtask
   // Every opcode back to back on lane-boundary operands
   task automatic t_all_ops;
      for (int i = 0; i < 24; i++) begin
         step(1, 4'(i % 12), i < 12 ? 32'h7FFF_8080 : 32'h8000_7F01,
              i < 12 ? 32'h0001_80FF : 32'hFFFF_0102, 1, 1);
      end
   endtask
   // False predicate, illegal codes and omitted destination
   task automatic t_refusals;
      step(1, 4'h0, 32'h1111_2222, 32'h0101_0101, 1, 1);
      step(1, 4'h1, 32'h5555_5555, 32'h0101_0101, 0, 1);
      for (int i = 12; i < 16; i++) step(1, 4'(i), 32'h0000_0001, 32'h0000_0001, 1, 1);
      step(1, 4'hC, 32'h0000_0001, 32'h0000_0001, 0, 1);
      step(1, 4'h8, 32'h0000_0000, 32'h0001_0001, 1, 0);
      step(0, 4'h0, 32'h0000_0000, 32'h0000_0000, 0, 0);
      step(0, 4'h0, 32'h0000_0000, 32'h0000_0000, 0, 0);
      check(peek, 32'h1212_2323);
   endtask
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_sys_rst <= 0;
      t_all_ops;
      t_refusals;
      wrap_up;
   end
   initial begin
      #(100 * 2000);
      failures++;
      wrap_up;
   end
endmodule
